// *** ch0_oc_prepare.sv ***
// Output prepare generator for the compare output control modes
`timescale 1ns/1ps
module ch0_oc_prepare
   import tmr_ch0_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [2:0]       oc_mode,
   input  wire logic             out_mode,
   input  wire logic             dir_down,
   input  wire logic [CNT_W-1:0] cnt,
   input  wire logic [CNT_W-1:0] cv,
   output logic                  match_rise,
   output logic                  oprep
);

   logic       eq_r;
   logic       rel_r;
   logic       dir_r;
   logic [2:0] mode_r;
   logic       rel;
   logic       pwm_chg;

   // Level of either pulse-width mode
   function automatic logic pwm_level(input logic inv, input logic down, input logic r);
      return (down ? !r : r) ^ inv;
   endfunction : pwm_level

   // Below while up, above while down
   assign rel        = dir_down ? (cnt > cv) : (cnt < cv);
   assign match_rise = (cnt == cv) && !eq_r;
   assign pwm_chg    = (mode_r == OC_TIMING) || (rel != rel_r) || (dir_down != dir_r);

   // History for edges and mode entry
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         eq_r   <= 1'b0;
         rel_r  <= 1'b0;
         dir_r  <= 1'b0;
         mode_r <= OC_CTL_RST;
      end
      else
      begin
         eq_r   <= cnt == cv;
         rel_r  <= rel;
         dir_r  <= dir_down;
         mode_r <= oc_mode;
      end
   end

   // Active-high prepare level
   always_ff @(posedge clk)
   begin
      if (srst)
         oprep <= 1'b0;
      else if (out_mode)
      begin
         unique case (oc_mode)
            OC_TIMING: oprep <= oprep;
            OC_SET:    if (match_rise) oprep <= 1'b1;
            OC_CLEAR:  if (match_rise) oprep <= 1'b0;
            OC_TOGGLE: if (match_rise) oprep <= !oprep;
            OC_FLOW:   oprep <= 1'b0;
            OC_FHIGH:  oprep <= 1'b1;
            OC_PWM0:   if (pwm_chg) oprep <= pwm_level(1'b0, dir_down, rel);
            OC_PWM1:   if (pwm_chg) oprep <= pwm_level(1'b1, dir_down, rel);
         endcase
      end
   end

endmodule : ch0_oc_prepare

// *** ch0_value_store.sv ***
// Compare value shadow and active registers with capture load
`timescale 1ns/1ps
module ch0_value_store
   import tmr_ch0_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             wr_en,
   input  wire logic [CNT_W-1:0] wr_data,
   input  wire logic             shadow_en,
   input  wire logic             upd_evt,
   input  wire logic             cap_en,
   input  wire logic [CNT_W-1:0] cap_val,
   output logic      [CNT_W-1:0] active_cv,
   output logic      [CNT_W-1:0] shadow_cv
);

   // Software side copy, also takes captures
   always_ff @(posedge clk)
   begin
      if (srst)
         shadow_cv <= CV_RST;
      else if (cap_en)
         shadow_cv <= cap_val;
      else if (wr_en)
         shadow_cv <= wr_data;
   end

   // Value the comparator uses
   always_ff @(posedge clk)
   begin
      if (srst)
         active_cv <= CV_RST;
      else if (cap_en)
         active_cv <= cap_val;
      else if (wr_en && !shadow_en)
         active_cv <= wr_data;
      else if (upd_evt && shadow_en)
         active_cv <= shadow_cv;
   end

endmodule : ch0_value_store

// *** test_timer_ch0_compare_event_gen.sv ***
// Register level tests of the channel 0 compare and event block
`timescale 1ns/1ps
module test_timer_ch0_compare_event_gen;
   import tmr_ch0_pkg::*;
   logic             clk = 1'h0, srst = 1'h1, dir = 1'h0, mdown = 1'h0;
   logic             awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic             arvalid = 1'h0, rready = 1'h0;
   logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]      wdata = 32'h0, rdata, rd;
   logic [3:0]       wstrb = 4'h0;
   logic [1:0]       bresp, rresp, rs;
   logic [CNT_W-1:0] cnt = 16'h0000;
   logic             hwu = 1'h0, fe = 1'h0;
   logic             awready, wready, bvalid, arready, rvalid;
   logic             c_clr, c_ld, p_clr, evp, prep, pin, npin;
   int               n_mismatch = 0, n_checks = 0, cyc = 0;
   int               n_clr = 0, n_ld = 0, n_psc = 0, n_ev = 0;

   initial
   forever #12.5 clk = ~clk;

   timer_ch0_compare_event_gen u_timer_ch0_compare_event_gen (
      .clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .counter_value(cnt), .count_dir_down(dir), .count_mode_down(mdown),
      .hw_update_evt(hwu), .filtered_edge_in(fe), .counter_clear(c_clr),
      .counter_load_reload(c_ld), .prescaler_clear(p_clr), .chan_event_pulse(evp),
      .output_prepare_sig(prep), .chan_output_pin(pin), .chan_compl_output_pin(npin));

   // Pulse tally, sampled away from the launching edge
   always @(negedge clk)
   begin
      n_clr += c_clr;
      n_ld  += c_ld;
      n_psc += p_clr;
      n_ev  += evp;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask : ticks

   // One write: both channels offered, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic pa, pw, t;
      pa = 1'h1;
      pw = 1'h1;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do
      begin
         @(negedge clk);
         t  = pa && awready;
         pa = pa && !awready;
         pw = pw && !wready;
         @(posedge clk);
         if (t)
            awvalid <= 1'h0;
         if (!pw)
            wvalid <= 1'h0;
      end while (pa || pw);
      do
      begin
         @(negedge clk);
         t  = bvalid;
         rs = bresp;
         @(posedge clk);
      end while (!t);
      bready <= 1'h0;
   endtask : wr

   // One read; result in rd and rs
   task automatic rdw(input logic [7:0] a);
      logic t;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do
      begin
         @(negedge clk);
         t = arready;
         @(posedge clk);
      end while (!t);
      arvalid <= 1'h0;
      do
      begin
         @(negedge clk);
         t  = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge clk);
      end while (!t);
      rready <= 1'h0;
   endtask : rdw

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rdw(a);
      chk(rd, exp);
   endtask : rdc

   // Mode {ctl, shadow}, counter c0 then c1, then prepare and pins
   task automatic cmp(input logic [3:0] m, input logic [15:0] c0, input logic [15:0] c1,
                      input logic d, input logic e);
      @(posedge clk);
      cnt <= c0;
      dir <= d;
      wr(OFF_MODE, {25'h0, m, 3'h0}, STRB_FULL);
      @(posedge clk);
      cnt <= c1;
      ticks(4);
      @(negedge clk);
      chk(prep, e);
      chk(pin, e);
      chk(npin, !e);
   endtask : cmp

   initial
   begin
      ticks(8);
      srst <= 1'h0;
      rdc(OFF_MODE, 32'h0);
      rdc(OFF_SWEVT, 32'h0);
      rdw(8'h3c);
      chk(rs, RESP_SLVERR);
      wr(OFF_MODE, 32'h50, 4'h3);
      rdc(OFF_MODE, 32'h0);
      $display("test bus done");
      wr(OFF_CV, 32'h10, STRB_FULL);
      wr(OFF_CHEN, 32'h5, STRB_FULL);
      cmp(4'ha, 16'h0, 16'h0, 1'h0, 1'h1);
      cmp(4'h0, 16'h0, 16'h10, 1'h0, 1'h1);
      cmp(4'h4, 16'h0, 16'h10, 1'h0, 1'h0);
      cmp(4'h2, 16'h0, 16'h10, 1'h0, 1'h1);
      cmp(4'h6, 16'h0, 16'h10, 1'h0, 1'h0);
      cmp(4'h8, 16'h10, 16'h10, 1'h0, 1'h0);
      cmp(4'hc, 16'h20, 16'h5, 1'h0, 1'h1);
      cmp(4'hc, 16'h5, 16'h20, 1'h0, 1'h0);
      cmp(4'hc, 16'h5, 16'h20, 1'h1, 1'h0);
      cmp(4'hc, 16'h20, 16'h5, 1'h1, 1'h1);
      cmp(4'he, 16'h20, 16'h5, 1'h0, 1'h0);
      cmp(4'he, 16'h5, 16'h20, 1'h0, 1'h1);
      cmp(4'he, 16'h5, 16'h20, 1'h1, 1'h1);
      cmp(4'he, 16'h20, 16'h5, 1'h1, 1'h0);
      $display("test compare modes done");
      wr(OFF_MODE, 32'h71, STRB_FULL);
      rdc(OFF_MODE, 32'h70);
      wr(OFF_CHEN, 32'h0, STRB_FULL);
      wr(OFF_MODE, 32'h1, STRB_FULL);
      rdc(OFF_MODE, 32'h1);
      wr(OFF_STATUS, 32'h0, STRB_FULL);
      n_ev = 0;
      cnt <= 16'h0123;
      wr(OFF_SWEVT, 32'h2, STRB_FULL);
      wr(OFF_SWEVT, 32'h2, STRB_FULL);
      rdw(OFF_STATUS);
      chk(rd & 32'h202, 32'h202);
      chk(n_ev, 2);
      rdc(OFF_CV, 32'h0123);
      rdw(OFF_STATUS);
      chk(rd & 32'h202, 32'h200);
      // Hardware edge capture needs the channel enabled
      wr(OFF_CHEN, 32'h1, STRB_FULL);
      cnt <= 16'h0456;
      @(posedge clk);
      fe <= 1'h1;
      @(posedge clk);
      fe <= 1'h0;
      rdc(OFF_CV, 32'h0456);
      wr(OFF_CHEN, 32'h0, STRB_FULL);
      $display("test capture done");
      wr(OFF_MODE, 32'h0, STRB_FULL);
      wr(OFF_CHEN, 32'h5, STRB_FULL);
      cmp(4'h9, 16'h0, 16'h0, 1'h0, 1'h0);
      wr(OFF_CV, 32'h30, STRB_FULL);
      cmp(4'h3, 16'h0, 16'h30, 1'h0, 1'h0);
      cnt <= 16'h0;
      wr(OFF_SWEVT, 32'h1, STRB_FULL);
      cmp(4'h3, 16'h0, 16'h30, 1'h0, 1'h1);
      mdown <= 1'h1;
      wr(OFF_SWEVT, 32'h1, STRB_FULL);
      wr(OFF_SWEVT, 32'h0, STRB_FULL);
      ticks(3);
      chk(n_clr, 1);
      chk(n_ld, 1);
      chk(n_psc, 2);
      chk(n_ev, 4);
      $display("test update done");
      // Pulse-width entry from timing mode, shadow kept on
      cmp(4'h1, 16'h40, 16'h40, 1'h0, 1'h1);
      cmp(4'hd, 16'h40, 16'h40, 1'h0, 1'h0);
      // Shadowed value moves on a hardware update
      wr(OFF_CV, 32'h50, STRB_FULL);
      @(posedge clk);
      hwu <= 1'h1;
      @(posedge clk);
      hwu <= 1'h0;
      ticks(3);
      @(negedge clk);
      chk(prep, 1'h1);
      wr(OFF_PROTECTION_LEVEL, 32'h300, STRB_FULL);
      wr(OFF_MODE, 32'h58, STRB_FULL);
      chk(rs, RESP_OKAY);
      rdc(OFF_MODE, 32'h68);
      $display("test lock done");
      test_done();
   end
endmodule : test_timer_ch0_compare_event_gen

// *** timer_ch0_compare_event_gen.sv ***
// Channel 0 compare and software event block with its AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module timer_ch0_compare_event_gen
   import tmr_ch0_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic      [1:0]       s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic      [31:0]      s_axi_rdata,
   output logic      [1:0]       s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic [CNT_W-1:0] counter_value,
   input  wire logic             count_dir_down,
   input  wire logic             count_mode_down,
   input  wire logic             hw_update_evt,
   input  wire logic             filtered_edge_in,
   output logic                  counter_clear,
   output logic                  counter_load_reload,
   output logic                  prescaler_clear,
   output logic                  chan_event_pulse,
   output logic                  output_prepare_sig,
   output logic                  chan_output_pin,
   output logic                  chan_compl_output_pin
);

   // Write channel state
   wr_state_e   wr_state_r;
   logic        aw_have_r;
   logic        w_have_r;
   logic [7:0]  wr_addr_r;
   logic [31:0] wr_data_r;
   logic [3:0]  wr_strb_r;
   logic [1:0]  bresp_r;
   logic        wr_do;
   logic        wr_ok;
   logic        wr_mapped;

   // Read channel state
   rd_state_e   rd_state_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        rd_take;
   logic [31:0] rd_word;
   logic        rd_mapped;

   // Register contents
   logic [2:0]  oc_ctl_r;
   logic        shadow_en_r;
   logic [1:0]  ioms_r;
   logic [3:0]  chen_r;
   logic [1:0]  protection_level_r;
   logic        irq_flag_r;
   logic        ovc_flag_r;

   // Register write strobes
   logic        we_status;
   logic        we_swevt;
   logic        we_mode;
   logic        we_chen;
   logic        we_cv;
   logic        we_protection_level;

   // Event pulses, mode decodes and other internal signals
   logic        chev_r;
   logic        upd_r;
   logic        upd_evt;
   logic        in_mode;
   logic        out_mode;
   logic        cap_evt;
   logic        cmp_evt;
   logic        match_rise;
   logic        irq_clr;
   logic        rd_cv_take;
   logic        mode_locked;
   logic        oprep;
   logic [CNT_W-1:0] active_cv;
   logic [CNT_W-1:0] shadow_cv;

   // Write handshakes, address and data taken in either order
   assign s_axi_awready = (wr_state_r == WR_COLLECT) && !aw_have_r;
   assign s_axi_wready  = (wr_state_r == WR_COLLECT) && !w_have_r;
   assign s_axi_bvalid  = wr_state_r == WR_RESP;
   assign s_axi_bresp   = bresp_r;
   assign wr_do         = (wr_state_r == WR_COLLECT) && aw_have_r && w_have_r;

   // Only full-word writes change registers
   assign wr_ok = wr_do && (wr_strb_r == STRB_FULL);

   // Decode of the held write address
   assign wr_mapped = addr_hit(wr_addr_r, OFF_STATUS) || addr_hit(wr_addr_r, OFF_SWEVT)
                      || addr_hit(wr_addr_r, OFF_MODE) || addr_hit(wr_addr_r, OFF_CHEN)
                      || addr_hit(wr_addr_r, OFF_CV) || addr_hit(wr_addr_r, OFF_PROTECTION_LEVEL);
   assign we_status = wr_ok && addr_hit(wr_addr_r, OFF_STATUS);
   assign we_swevt  = wr_ok && addr_hit(wr_addr_r, OFF_SWEVT);
   assign we_mode   = wr_ok && addr_hit(wr_addr_r, OFF_MODE);
   assign we_chen   = wr_ok && addr_hit(wr_addr_r, OFF_CHEN);
   assign we_cv     = wr_ok && addr_hit(wr_addr_r, OFF_CV);
   assign we_protection_level   = wr_ok && addr_hit(wr_addr_r, OFF_PROTECTION_LEVEL);

   // Hold address and data until both are present
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 32'h0000_0000;
         wr_strb_r <= 4'h0;
      end
      else if (wr_do)
      begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            wr_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r  <= 1'b1;
            wr_data_r <= s_axi_wdata;
            wr_strb_r <= s_axi_wstrb;
         end
      end
   end

   // Write response sequencing
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_state_r <= WR_COLLECT;
         bresp_r    <= RESP_OKAY;
      end
      else
      begin
         unique case (wr_state_r)
            WR_COLLECT:
               if (wr_do)
               begin
                  wr_state_r <= WR_RESP;
                  bresp_r    <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
               end
            WR_RESP:
               if (s_axi_bready)
                  wr_state_r <= WR_COLLECT;
            default:
               wr_state_r <= WR_COLLECT;
         endcase
      end
   end

   // Read handshakes
   assign s_axi_arready = rd_state_r == RD_IDLE;
   assign s_axi_rvalid  = rd_state_r == RD_RESP;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign rd_take       = s_axi_arvalid && s_axi_arready;
   assign rd_cv_take    = rd_take && addr_hit(s_axi_araddr, OFF_CV);

   // Read data selection, trigger bits always zero
   always_comb
   begin
      rd_word   = 32'h0000_0000;
      rd_mapped = 1'b1;
      if (addr_hit(s_axi_araddr, OFF_STATUS))
      begin
         rd_word[ST_IRQ_BIT] = irq_flag_r;
         rd_word[ST_OVC_BIT] = ovc_flag_r;
      end
      else if (addr_hit(s_axi_araddr, OFF_SWEVT))
         rd_word = 32'h0000_0000;
      else if (addr_hit(s_axi_araddr, OFF_MODE))
      begin
         rd_word[MODE_CTL_LSB +: 3]  = oc_ctl_r;
         rd_word[MODE_SEN_BIT]       = shadow_en_r;
         rd_word[MODE_IOMS_LSB +: 2] = ioms_r;
      end
      else if (addr_hit(s_axi_araddr, OFF_CHEN))
         rd_word[3:0] = chen_r;
      else if (addr_hit(s_axi_araddr, OFF_CV))
         rd_word[CNT_W-1:0] = shadow_cv;
      else if (addr_hit(s_axi_araddr, OFF_PROTECTION_LEVEL))
         rd_word[PROTECTION_LEVEL_LSB +: 2] = protection_level_r;
      else
         rd_mapped = 1'b0;
   end

   // Read response sequencing
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_state_r <= RD_IDLE;
         rdata_r    <= 32'h0000_0000;
         rresp_r    <= RESP_OKAY;
      end
      else
      begin
         unique case (rd_state_r)
            RD_IDLE:
               if (rd_take)
               begin
                  rd_state_r <= RD_RESP;
                  rdata_r    <= rd_word;
                  rresp_r    <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
               end
            RD_RESP:
               if (s_axi_rready)
                  rd_state_r <= RD_IDLE;
            default:
               rd_state_r <= RD_IDLE;
         endcase
      end
   end

   // Channel mode decode
   assign out_mode    = ioms_r == IOMS_OUTPUT;
   assign in_mode     = ioms_r == IOMS_INPUT;
   assign mode_locked = (protection_level_r == PROTECTION_LEVEL_LOCKED) && out_mode;

   // Channel mode register with write locks
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         oc_ctl_r    <= OC_CTL_RST;
         shadow_en_r <= 1'b0;
         ioms_r      <= IOMS_RST;
      end
      else if (we_mode)
      begin
         if (!mode_locked)
         begin
            oc_ctl_r    <= wr_data_r[MODE_CTL_LSB +: 3];
            shadow_en_r <= wr_data_r[MODE_SEN_BIT];
         end
         if (!chen_r[CHEN_EN_BIT])
            ioms_r <= wr_data_r[MODE_IOMS_LSB +: 2];
      end
   end

   // Channel enable and protection registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         chen_r <= CHEN_RST;
         protection_level_r <= PROTECTION_LEVEL_RST;
      end
      else
      begin
         if (we_chen)
            chen_r <= wr_data_r[3:0];
         if (we_protection_level)
            protection_level_r <= wr_data_r[PROTECTION_LEVEL_LSB +: 2];
      end
   end

   // Software triggers act once, then drop back to zero
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         chev_r              <= 1'b0;
         upd_r               <= 1'b0;
         counter_clear       <= 1'b0;
         counter_load_reload <= 1'b0;
         prescaler_clear     <= 1'b0;
      end
      else
      begin
         chev_r              <= we_swevt && wr_data_r[SW_CHEV_BIT];
         upd_r               <= we_swevt && wr_data_r[SW_UPD_BIT];
         counter_clear       <= we_swevt && wr_data_r[SW_UPD_BIT] && !count_mode_down;
         counter_load_reload <= we_swevt && wr_data_r[SW_UPD_BIT] && count_mode_down;
         prescaler_clear     <= we_swevt && wr_data_r[SW_UPD_BIT];
      end
   end

   // Capture and compare events
   assign upd_evt = upd_r || hw_update_evt;
   assign cap_evt = in_mode && (chev_r || (filtered_edge_in && chen_r[CHEN_EN_BIT]));
   assign cmp_evt = out_mode && (chev_r || match_rise);

   // Flag clear by software zero write or by value read in input mode
   assign irq_clr = (we_status && !wr_data_r[ST_IRQ_BIT]) || (rd_cv_take && in_mode);

   // Channel flag, a set beats a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (srst)
         irq_flag_r <= 1'b0;
      else if (cap_evt || cmp_evt)
         irq_flag_r <= 1'b1;
      else if (irq_clr)
         irq_flag_r <= 1'b0;
   end

   // Over-capture flag
   always_ff @(posedge clk)
   begin
      if (srst)
         ovc_flag_r <= 1'b0;
      else if (cap_evt && irq_flag_r)
         ovc_flag_r <= 1'b1;
      else if (we_status && !wr_data_r[ST_OVC_BIT])
         ovc_flag_r <= 1'b0;
   end

   // Request pulse toward interrupt and DMA logic
   always_ff @(posedge clk)
   begin
      if (srst)
         chan_event_pulse <= 1'b0;
      else
         chan_event_pulse <= cap_evt || cmp_evt;
   end

   // Compare value with optional shadow
   ch0_value_store u_value
   (
      .clk       (clk),
      .srst      (srst),
      .wr_en     (we_cv),
      .wr_data   (wr_data_r[CNT_W-1:0]),
      .shadow_en (shadow_en_r),
      .upd_evt   (upd_evt),
      .cap_en    (cap_evt),
      .cap_val   (counter_value),
      .active_cv (active_cv),
      .shadow_cv (shadow_cv)
   );

   // Output prepare generation
   ch0_oc_prepare u_prepare
   (
      .clk        (clk),
      .srst       (srst),
      .oc_mode    (oc_ctl_r),
      .out_mode   (out_mode),
      .dir_down   (count_dir_down),
      .cnt        (counter_value),
      .cv         (active_cv),
      .match_rise (match_rise),
      .oprep      (oprep)
   );

   assign output_prepare_sig = oprep;

   // Pin levels from active-high prepare and polarity bits
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         chan_output_pin       <= 1'b0;
         chan_compl_output_pin <= 1'b0;
      end
      else
      begin
         chan_output_pin       <= chen_r[CHEN_EN_BIT] && (oprep ^ chen_r[CHEN_POL_BIT]);
         chan_compl_output_pin <= chen_r[CHEN_NEN_BIT]
                                  && (!oprep ^ chen_r[CHEN_NPOL_BIT]);
      end
   end

endmodule : timer_ch0_compare_event_gen

// *** timer_ch0_compare_event_gen_monitor.sv ***
// Bus handshake and event pulse checks for the channel 0 compare block
`timescale 1ns/1ps
module timer_ch0_compare_event_gen_monitor
   import tmr_ch0_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic counter_clear,
   input wire logic counter_load_reload,
   input wire logic prescaler_clear,
   input wire logic chan_event_pulse
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // Address and data taken at one edge
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Either kind of update pulse
   sequence upd_pulse;
      counter_clear || counter_load_reload;
   endsequence

   AST_WR_ANS: assert property (wr_both |-> ##[2:3] s_axi_bvalid)
      else $error("write answer late");
   AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("write answer not retired");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not retired");
   AST_W_BLK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   AST_EVT_ONE: assert property (chan_event_pulse |=> !chan_event_pulse)
      else $error("channel event pulse too long");
   AST_UPD_PSC: assert property (upd_pulse |-> prescaler_clear)
      else $error("update without prescaler clear");
   AST_UPD_EXCL: assert property (counter_clear |-> !counter_load_reload)
      else $error("clear and reload together");
   AST_UPD_ONE: assert property (upd_pulse |=> !prescaler_clear)
      else $error("update trigger not self cleared");
endmodule : timer_ch0_compare_event_gen_monitor

bind timer_ch0_compare_event_gen timer_ch0_compare_event_gen_monitor
   u_timer_ch0_compare_event_gen_monitor (.*);

// *** tmr_ch0_pkg.sv ***
// Constants, encodings and helpers for the channel 0 compare and event block
package tmr_ch0_pkg;

   // Data path widths
   localparam int CNT_W = 16;

   // Register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_SWEVT  = 8'h14;
   localparam logic [7:0] OFF_MODE   = 8'h18;
   localparam logic [7:0] OFF_CHEN   = 8'h20;
   localparam logic [7:0] OFF_CV     = 8'h34;
   localparam logic [7:0] OFF_PROTECTION_LEVEL   = 8'h44;

   // Field positions
   localparam int ST_IRQ_BIT    = 1;
   localparam int ST_OVC_BIT    = 9;
   localparam int SW_UPD_BIT    = 0;
   localparam int SW_CHEV_BIT   = 1;
   localparam int MODE_IOMS_LSB = 0;
   localparam int MODE_SEN_BIT  = 3;
   localparam int MODE_CTL_LSB  = 4;
   localparam int CHEN_EN_BIT   = 0;
   localparam int CHEN_POL_BIT  = 1;
   localparam int CHEN_NEN_BIT  = 2;
   localparam int CHEN_NPOL_BIT = 3;
   localparam int PROTECTION_LEVEL_LSB      = 8;

   // Reset values
   localparam logic [2:0]       OC_CTL_RST = 3'h0;
   localparam logic [1:0]       IOMS_RST   = 2'h0;
   localparam logic [3:0]       CHEN_RST   = 4'h0;
   localparam logic [1:0]       PROTECTION_LEVEL_RST   = 2'h0;
   localparam logic [CNT_W-1:0] CV_RST     = 16'h0000;

   // Channel I/O mode codes and the locked protection level code
   localparam logic [1:0] IOMS_OUTPUT = 2'h0;
   localparam logic [1:0] IOMS_INPUT  = 2'h1;
   localparam logic [1:0] PROTECTION_LEVEL_LOCKED = 2'h3;

   // Compare output control codes
   localparam logic [2:0] OC_TIMING = 3'h0;
   localparam logic [2:0] OC_SET    = 3'h1;
   localparam logic [2:0] OC_CLEAR  = 3'h2;
   localparam logic [2:0] OC_TOGGLE = 3'h3;
   localparam logic [2:0] OC_FLOW   = 3'h4;
   localparam logic [2:0] OC_FHIGH  = 3'h5;
   localparam logic [2:0] OC_PWM0   = 3'h6;
   localparam logic [2:0] OC_PWM1   = 3'h7;

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] STRB_FULL   = 4'hf;

   // Bus channel states
   typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} wr_state_e;
   typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_e;

   // Word address match
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction : addr_hit

endpackage : tmr_ch0_pkg
